/* hdl/twr_pkg.sv */
// Shared constants for the two-wire register access link.
// Assumes both ends run on clk_sys at 100 MHz.
package twr_pkg;
  localparam logic [6:0] DEV_ADDR_BASE  = 7'h3c;
  localparam logic [6:0] DEV_ADDR_ALT   = 7'h3d;
  localparam int         BYTE_BITS      = 8;
  localparam int         SYNC_STAGES    = 3;
  localparam int         CLK_MHZ        = 100;
  localparam int         HALF_PERIOD_NS = 250;
  localparam int         HALF_CYCLES    = HALF_PERIOD_NS * CLK_MHZ / 1000;
  localparam logic [15:0] REG_ADDR_RST  = 16'h0000;
  localparam logic [7:0]  BYTE_RST      = 8'h00;
endpackage

/* hdl/twr_if.sv */
// Two-wire link between the host master and the register slave.
// Both lines are open drain with an external pull-up.
`timescale 1ns/100ps
interface twr_if;
  logic scl_oe;
  logic sda_m_oe;
  logic sda_s_oe;
  logic scl_in;
  logic sda_in;
  assign scl_in = ~scl_oe;
  assign sda_in = ~(sda_m_oe | sda_s_oe);
  modport master (output scl_oe, output sda_m_oe,
                  input scl_in, input sda_in);
  modport slave (output sda_s_oe, input scl_in, input sda_in);
endinterface

/* hdl/twr_slave.sv */
// Slave end of the two-wire register access link.
// Assumes an external register store answering reads in the same cycle.
// Functional notes
// - Message bytes carry address, write and read data.
// - Every byte is followed by one acknowledge slot.
// - Sender releases data; receiver pulls low to acknowledge.
// - Data changes only while serial clock low.
// - Data left high means no-acknowledge, ends reads.
// - Stop is data rising with clock high.
// - Compare seven address bits, acknowledge only on match.
// - Write sends 16-bit register address high byte first.
// - Acknowledge write bytes, increment address after each.
// - Master ends writes with stop or restart.
// - Random read is dummy write then restart read.
// - Reads shift bytes out, incrementing address.
// - Master acknowledges to continue, no-acknowledge ends.
// - Master should end writes with stop.
// - Start is data falling with clock high.
// - Bytes go most significant bit first.
// - Address 0x78/0x79, alternate 0x7a/0x7b when selected.
`timescale 1ns/100ps
module twr_slave
  import twr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  twr_if.slave             bus,
  input  wire logic        alt_address_select,
  output logic [15:0]      wr_addr,
  output logic [7:0]       wr_data,
  output logic             wr_en,
  output logic [15:0]      rd_addr,
  input  wire logic [7:0]  rd_data,
  output logic             rd_en
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV  = 3'b001,
    ST_RX   = 3'b010,
    ST_TX   = 3'b011,
    ST_ACK  = 3'b100,
    ST_MACK = 3'b101,
    ST_SKIP = 3'b110
  } state_type;

  logic [SYNC_STAGES-1:0] scl_sync_r;
  logic [SYNC_STAGES-1:0] sda_sync_r;
  logic                   scl_r;
  logic                   sda_r;
  logic                   scl_prev_r;
  logic                   sda_prev_r;
  state_type              state_r;
  logic [7:0]             shift_r;
  logic [3:0]             bits_r;
  logic [1:0]             phase_r;
  logic                   read_r;
  logic                   ack_r;
  logic [15:0]            addr_r;
  logic                   sda_oe_r;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_det;
  logic                   stop_det;
  logic [6:0]             my_addr;

  // Lines pass three flops; a change counts when the last two agree.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_r <= '1;
      sda_sync_r <= '1;
      scl_r      <= 1'b1;
      sda_r      <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[1:0], bus.scl_in};
      sda_sync_r <= {sda_sync_r[1:0], bus.sda_in};
      if (scl_sync_r[2] == scl_sync_r[1]) begin
        scl_r <= scl_sync_r[2];
      end
      if (sda_sync_r[2] == sda_sync_r[1]) begin
        sda_r <= sda_sync_r[2];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_prev_r <= scl_r;
      sda_prev_r <= sda_r;
    end
  end

  assign scl_rise  = scl_r & ~scl_prev_r;
  assign scl_fall  = ~scl_r & scl_prev_r;
  assign start_det = scl_r & scl_prev_r & sda_prev_r & ~sda_r;
  assign stop_det  = scl_r & scl_prev_r & ~sda_prev_r & sda_r;
  assign my_addr   = alt_address_select ? DEV_ADDR_ALT
                                        : DEV_ADDR_BASE;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= ST_IDLE;
      shift_r  <= BYTE_RST;
      bits_r   <= '0;
      phase_r  <= '0;
      read_r   <= 1'b0;
      ack_r    <= 1'b0;
      addr_r   <= REG_ADDR_RST;
      sda_oe_r <= 1'b0;
      wr_en    <= 1'b0;
      wr_data  <= BYTE_RST;
      wr_addr  <= REG_ADDR_RST;
      rd_en    <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      if (stop_det) begin
        state_r  <= ST_IDLE;
        sda_oe_r <= 1'b0;
      end else if (start_det) begin
        state_r  <= ST_DEV;
        bits_r   <= '0;
        sda_oe_r <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE, ST_SKIP: begin
            sda_oe_r <= 1'b0;
          end
          ST_DEV, ST_RX: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_r};
              bits_r  <= bits_r + 4'd1;
            end else if (scl_fall && bits_r == 4'(BYTE_BITS)) begin
              bits_r <= '0;
              if (state_r == ST_DEV) begin
                read_r <= shift_r[0];
                ack_r  <= (shift_r[7:1] == my_addr);
                phase_r <= '0;
              end else begin
                ack_r <= 1'b1;
                case (phase_r)
                  2'd0: begin
                    addr_r[15:8] <= shift_r;
                    phase_r      <= 2'd1;
                  end
                  2'd1: begin
                    addr_r[7:0] <= shift_r;
                    phase_r     <= 2'd2;
                  end
                  default: begin
                    wr_addr <= addr_r;
                    wr_data <= shift_r;
                    wr_en   <= 1'b1;
                    addr_r  <= addr_r + 16'd1;
                  end
                endcase
              end
              if (state_r == ST_RX || shift_r[7:1] == my_addr) begin
                sda_oe_r <= 1'b1;
              end
              state_r <= ST_ACK;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (!ack_r) begin
                sda_oe_r <= 1'b0;
                state_r  <= ST_SKIP;
              end else if (read_r) begin
                shift_r  <= rd_data;
                rd_en    <= 1'b1;
                addr_r   <= addr_r + 16'd1;
                sda_oe_r <= ~rd_data[7];
                bits_r   <= 4'd1;
                state_r  <= ST_TX;
              end else begin
                sda_oe_r <= 1'b0;
                state_r  <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bits_r == 4'(BYTE_BITS)) begin
                sda_oe_r <= 1'b0;
                state_r  <= ST_MACK;
              end else begin
                sda_oe_r <= ~shift_r[6];
                shift_r  <= {shift_r[6:0], 1'b0};
                bits_r   <= bits_r + 4'd1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              ack_r <= ~sda_r;
            end else if (scl_fall) begin
              if (ack_r) begin
                shift_r  <= rd_data;
                rd_en    <= 1'b1;
                addr_r   <= addr_r + 16'd1;
                sda_oe_r <= ~rd_data[7];
                bits_r   <= 4'd1;
                state_r  <= ST_TX;
              end else begin
                state_r <= ST_SKIP;
              end
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  assign rd_addr      = addr_r;
  assign bus.sda_s_oe = sda_oe_r;
endmodule

/* hdl/twr_master.sv */
// Host master end of the two-wire register access link.
// Assumes the user holds cmd fields steady while busy is high.
`timescale 1ns/100ps
module twr_master
  import twr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  twr_if.master            bus,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_start,
  input  wire logic        cmd_stop,
  input  wire logic        cmd_read,
  input  wire logic        cmd_nack,
  input  wire logic [7:0]  cmd_data,
  output logic             busy,
  output logic             done,
  output logic [7:0]       rx_data,
  output logic             rx_ack
);
  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_START = 3'b001,
    M_BIT   = 3'b010,
    M_ACK   = 3'b011,
    M_STOP  = 3'b100
  } mstate_type;

  mstate_type  state_r;
  logic [15:0] cnt_r;
  logic [1:0]  q_r;
  logic [3:0]  bits_r;
  logic [7:0]  sh_r;
  logic        scl_oe_r;
  logic        sda_oe_r;
  logic        stop_r;
  logic        read_r;
  logic        nack_r;
  logic        tick;

  assign tick = (cnt_r == 16'(HALF_CYCLES - 1));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (state_r == M_IDLE || tick) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 16'd1;
    end
  end

  // Each bit is four quarter steps: low, low-set, high, high-hold.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= M_IDLE;
      q_r      <= '0;
      bits_r   <= '0;
      sh_r     <= BYTE_RST;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      stop_r   <= 1'b0;
      read_r   <= 1'b0;
      nack_r   <= 1'b0;
      done     <= 1'b0;
      rx_data  <= BYTE_RST;
      rx_ack   <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_r)
        M_IDLE: begin
          if (cmd_valid) begin
            sh_r   <= cmd_data;
            stop_r <= cmd_stop;
            read_r <= cmd_read;
            nack_r <= cmd_nack;
            q_r    <= '0;
            bits_r <= '0;
            state_r <= cmd_start ? M_START : M_BIT;
          end
        end
        M_START: begin
          if (tick) begin
            q_r <= q_r + 2'd1;
            case (q_r)
              2'd0: sda_oe_r <= 1'b0;
              2'd1: scl_oe_r <= 1'b0;
              2'd2: sda_oe_r <= 1'b1;
              default: begin
                scl_oe_r <= 1'b1;
                state_r  <= M_BIT;
              end
            endcase
          end
        end
        M_BIT, M_ACK: begin
          if (tick) begin
            q_r <= q_r + 2'd1;
            case (q_r)
              2'd0: begin
                if (state_r == M_ACK) begin
                  sda_oe_r <= read_r & ~nack_r;
                end else begin
                  sda_oe_r <= ~read_r & ~sh_r[7];
                end
              end
              2'd1: scl_oe_r <= 1'b0;
              2'd2: begin
                if (state_r == M_ACK) begin
                  rx_ack <= ~bus.sda_in;
                end else begin
                  rx_data <= {rx_data[6:0], bus.sda_in};
                end
              end
              default: begin
                scl_oe_r <= 1'b1;
                if (state_r == M_ACK) begin
                  sda_oe_r <= 1'b0;
                  if (stop_r) begin
                    state_r <= M_STOP;
                  end else begin
                    done    <= 1'b1;
                    state_r <= M_IDLE;
                  end
                end else begin
                  sh_r   <= {sh_r[6:0], 1'b0};
                  bits_r <= bits_r + 4'd1;
                  if (bits_r == 4'(BYTE_BITS - 1)) begin
                    state_r <= M_ACK;
                  end
                end
              end
            endcase
          end
        end
        M_STOP: begin
          if (tick) begin
            q_r <= q_r + 2'd1;
            case (q_r)
              2'd0: sda_oe_r <= 1'b1;
              2'd1: scl_oe_r <= 1'b0;
              2'd2: sda_oe_r <= 1'b0;
              default: begin
                done    <= 1'b1;
                state_r <= M_IDLE;
              end
            endcase
          end
        end
        default: state_r <= M_IDLE;
      endcase
    end
  end

  assign busy         = (state_r != M_IDLE);
  assign bus.scl_oe   = scl_oe_r;
  assign bus.sda_m_oe = sda_oe_r;
endmodule

/* verification/twr_checker.sv */
// Checker for the two-wire link, watching the shared interface lines.
// Assumes one clock domain and slave address bytes 0x78 to 0x7b.
`timescale 1ns/100ps
module twr_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic scl_in,
  input wire logic sda_in
);
  logic       scl_r;
  logic       sda_r;
  logic       first_r;
  logic       rd_r;
  logic       act_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic       rise;
  logic       start;
  logic       stop;
  logic       slot;
  assign rise  = scl_in & ~scl_r;
  assign start = scl_in & scl_r & sda_r & ~sda_in;
  assign stop  = scl_in & scl_r & ~sda_r & sda_in;
  assign slot  = rise & (cnt_r == 4'h8);
  // Delayed line samples for edge and condition detection.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {scl_r, sda_r} <= 2'h3;
    end else begin
      {scl_r, sda_r} <= {scl_in, sda_in};
    end
  end
  // Tracks bit position, first byte, direction and whether addressed.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {cnt_r, first_r, rd_r, act_r, sh_r} <= 15'h0;
    end else if (start) begin
      {cnt_r, first_r, act_r} <= 6'h3;
    end else if (stop) begin
      act_r <= 1'b0;
    end else if (rise) begin
      cnt_r <= (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
      if (cnt_r < 4'h8) sh_r <= {sh_r[6:0], sda_in};
      if (slot && first_r) rd_r <= sh_r[0];
      if (slot && first_r && sda_in) act_r <= 1'b0;
      if (cnt_r == 4'h9) first_r <= 1'b0;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_slot9;
    slot && act_r && !first_r;
  endsequence
  sequence s_ack_fall;
    $fell(scl_in) && cnt_r == 4'h9 && act_r && !rd_r;
  endsequence
  property p_stable_high;
    scl_in && $past(scl_in) |-> $stable(sda_s_oe);
  endproperty
  property p_sync_change;
    $changed(sda_s_oe) |-> !scl_in && !$past(scl_in, 2);
  endproperty
  property p_no_match;
    slot && first_r && act_r && sh_r[7:2] != 6'h1e |-> !sda_s_oe;
  endproperty
  property p_write_ack;
    s_slot9 ##0 !rd_r |-> sda_s_oe;
  endproperty
  property p_read_release;
    s_slot9 ##0 rd_r |-> !sda_s_oe;
  endproperty
  property p_write_quiet;
    rise && cnt_r < 4'h8 && act_r && (first_r || !rd_r) |-> !sda_s_oe;
  endproperty
  property p_ack_released;
    s_ack_fall |-> ##[1:12] !sda_s_oe;
  endproperty
  property p_stop_idle;
    stop |=> !sda_s_oe [*8];
  endproperty
  property p_master_release;
    s_slot9 ##0 !rd_r |-> !sda_m_oe;
  endproperty
  property p_master_stable;
    $changed(sda_m_oe) && !scl_oe |-> start || stop;
  endproperty
  a_stable_high: assert property (p_stable_high)
    else $error("slave data moved while clock high");
  a_sync_change: assert property (p_sync_change)
    else $error("slave data moved too soon after clock fall");
  a_no_match: assert property (p_no_match)
    else $error("slave acked a foreign address");
  a_write_ack: assert property (p_write_ack)
    else $error("slave missed a write acknowledge");
  a_read_release: assert property (p_read_release)
    else $error("slave held data in master slot");
  a_write_quiet: assert property (p_write_quiet)
    else $error("slave drove data while receiving");
  a_ack_released: assert property (p_ack_released)
    else $error("slave kept acknowledge too long");
  a_stop_idle: assert property (p_stop_idle)
    else $error("slave drove data after stop");
  a_master_release: assert property (p_master_release)
    else $error("master held data in slave acknowledge slot");
  a_master_stable: assert property (p_master_stable)
    else $error("master data moved while clock high");
endmodule

/* verification/two_wire_register_slave_test.sv */
// Testbench joining master and slave ends across the shared interface.
// Assumes a byte-wide register store modelled here on the slave side.
`timescale 1ns/100ps
module two_wire_register_slave_test;
  import twr_pkg::*;
  logic        clk_sys, rst_n, alt_address_select, busy, done, rx_ack;
  logic        cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_nack;
  logic [7:0]  cmd_data, rx_data, wr_data, rd_data;
  logic        wr_en, rd_en;
  logic [15:0] wr_addr, rd_addr;
  logic [7:0]  mem [0:255];
  int          ref_mem [0:255];
  int          exp_q [$];
  int          fail_count, num_checks, seed, cycles, model_addr, i;
  int          rd_count, exp_rd;
  logic [15:0] a;
  twr_if bus_if();
  twr_master u_twr_master (.clk_sys(clk_sys), .rst_n(rst_n),
    .bus(bus_if.master), .cmd_valid(cmd_valid), .cmd_start(cmd_start),
    .cmd_stop(cmd_stop), .cmd_read(cmd_read), .cmd_nack(cmd_nack),
    .cmd_data(cmd_data), .busy(busy), .done(done), .rx_data(rx_data),
    .rx_ack(rx_ack));
  twr_slave u_twr_slave (.clk_sys(clk_sys), .rst_n(rst_n),
    .bus(bus_if.slave), .alt_address_select(alt_address_select),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_en(rd_en));
  twr_checker u_twr_checker (.clk_sys(clk_sys), .rst_n(rst_n),
    .scl_oe(bus_if.scl_oe), .sda_m_oe(bus_if.sda_m_oe),
    .sda_s_oe(bus_if.sda_s_oe), .scl_in(bus_if.scl_in),
    .sda_in(bus_if.sda_in));
  assign rd_data = mem[rd_addr[7:0]];
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Counts cycles and ends the run when the ceiling is reached.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // Stores writes, counts read loads and compares with the model.
  always @(negedge clk_sys) begin
    if (rd_en === 1'b1) begin
      rd_count++;
    end
    if (wr_en === 1'b1) begin
      mem[wr_addr[7:0]] <= wr_data;
      if (exp_q.size() == 0) check(1, 0);
      else check({wr_addr, wr_data}, exp_q.pop_front());
    end
  end
  // Sends one byte command and waits for its completion.
  task automatic xfer(input logic st, sp, rd, nk, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk_sys);
    {cmd_valid, cmd_start, cmd_stop} = {1'b1, st, sp};
    {cmd_read, cmd_nack} = {rd, nk};
    cmd_data = d;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    check(busy, 1);
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (done !== 1'b1 && n < 5000);
    check(done, 1);
    check(busy, 0);
  endtask
  task automatic wr_seq(input logic [7:0] dev, input logic [15:0] ad,
                        input int len, input logic ok, input logic sp);
    logic [7:0] d;
    xfer(1'b1, !ok, 1'b0, 1'b0, dev);
    check(rx_ack, ok);
    if (ok) begin
      xfer(1'b0, 1'b0, 1'b0, 1'b0, ad[15:8]);
      check(rx_ack, 1);
      xfer(1'b0, len == 0 && sp, 1'b0, 1'b0, ad[7:0]);
      check(rx_ack, 1);
      model_addr = ad;
      for (int k = 0; k < len; k++) begin
        d = 8'($random(seed));
        exp_q.push_back({model_addr[15:0], d});
        ref_mem[model_addr[7:0]] = d;
        model_addr = (model_addr + 1) & 16'hffff;
        xfer(1'b0, k == len - 1 && sp, 1'b0, 1'b0, d);
        check(rx_ack, 1);
      end
    end
  endtask
  task automatic rd_seq(input logic [7:0] dev, input int len);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, dev);
    check(rx_ack, 1);
    for (int k = 0; k < len; k++) begin
      xfer(1'b0, k == len - 1, 1'b1, k == len - 1, 8'h00);
      check(rx_data, ref_mem[model_addr[7:0]]);
      model_addr = (model_addr + 1) & 16'hffff;
      exp_rd++;
      check(rd_count, exp_rd);
      check(rd_addr, model_addr);
    end
  endtask
  initial begin
    {rst_n, alt_address_select, cmd_valid, cmd_start} = 4'h0;
    {cmd_stop, cmd_read, cmd_nack, cmd_data} = 11'h000;
    seed = 53;
    cycles = 0;
    fail_count = 0;
    num_checks = 0;
    model_addr = 0;
    rd_count = 0;
    exp_rd = 0;
    for (i = 0; i < 256; i++) begin
      mem[i] = i[7:0] ^ 8'h5a;
      ref_mem[i] = i ^ 8'h5a;
    end
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    a = 16'($random(seed));
    wr_seq({DEV_ADDR_BASE, 1'b0}, a, 3, 1'b1, 1'b1);
    wr_seq({DEV_ADDR_BASE, 1'b0}, a, 0, 1'b1, 1'b0);
    rd_seq({DEV_ADDR_BASE, 1'b1}, 4);
    rd_seq({DEV_ADDR_BASE, 1'b1}, 1);
    wr_seq(8'h50, a, 0, 1'b0, 1'b1);
    @(negedge clk_sys);
    alt_address_select = 1'b1;
    a = 16'($random(seed));
    wr_seq({DEV_ADDR_ALT, 1'b0}, a, 2, 1'b1, 1'b1);
    wr_seq({DEV_ADDR_BASE, 1'b0}, a, 0, 1'b0, 1'b1);
    wr_seq({DEV_ADDR_ALT, 1'b0}, a, 0, 1'b1, 1'b0);
    rd_seq({DEV_ADDR_ALT, 1'b1}, 2);
    check(exp_q.size(), 0);
    report_and_stop();
  end
endmodule
